// File: inc/mecc_pkg.sv
// Constants, carrier types and code functions for the SECDED memory block.
// Assumes a single clock domain; used only through mecc_pkg:: names.
package mecc_pkg;

    // ------------------------------------------------------------
    // Geometry and register map
    // ------------------------------------------------------------
    localparam int         DATA_W    = 64;
    localparam int         CHK_W     = 8;
    localparam int         WORD_W    = 72;
    localparam int         ADDR_W    = 9;
    localparam int         DEPTH     = 512;
    localparam int         HAM_LAST  = 71;
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_PTR   = 8'h08;
    localparam logic [3:0] CTRL_RST  = 4'h0;
    localparam logic [1:0] STAT_RST  = 2'h0;
    localparam int         STAT_SBE  = 0;
    localparam int         STAT_DBE  = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic fifo;
        logic oreg;
        logic dec;
        logic enc;
    } mecc_cfg_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CHK_W-1:0]  check;
        logic              sbe;
        logic              dbe;
    } mecc_rd_t;

    // ------------------------------------------------------------
    // Hamming check bits plus overall parity in bit 7
    // ------------------------------------------------------------
    function automatic logic [CHK_W-1:0] mecc_gen(input logic [DATA_W-1:0] d);
        logic [CHK_W-1:0] c;
        int               j;
        c = 8'h00;
        j = 0;
        for (int p = 1; p <= HAM_LAST; p++) begin
            if ((p & (p - 1)) != 0) begin
                for (int b = 0; b < 7; b++) begin
                    if (p[b]) c[b] = c[b] ^ d[j];
                end
                j++;
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction : mecc_gen

    // ------------------------------------------------------------
    // Read view: raw word, or decoded and corrected word
    // ------------------------------------------------------------
    function automatic mecc_rd_t mecc_view(input logic [WORD_W-1:0] w, input logic dec);
        mecc_rd_t         r;
        logic [CHK_W-1:0] syn;
        logic [6:0]       s;
        int               j;
        r.data  = w[DATA_W-1:0];
        r.check = w[WORD_W-1:DATA_W];
        r.sbe   = 1'b0;
        r.dbe   = 1'b0;
        syn     = mecc_gen(w[DATA_W-1:0]) ^ w[WORD_W-1:DATA_W];
        s       = syn[6:0];
        j       = 0;
        if (dec) begin
            if (^w) begin
                r.sbe = 1'b1;
                if (s == 7'h00) begin
                    r.check[7] = ~r.check[7];
                end else if (s > 7'h47) begin
                    r.sbe = 1'b0;
                    r.dbe = 1'b1;
                end else begin
                    for (int p = 1; p <= HAM_LAST; p++) begin
                        if ((p & (p - 1)) == 0) begin
                            if (p == int'(s)) r.check[6:0] = r.check[6:0] ^ p[6:0];
                        end else begin
                            if (p == int'(s)) r.data[j] = ~r.data[j];
                            j++;
                        end
                    end
                end
            end else if (s != 7'h00) begin
                r.dbe = 1'b1;
            end
        end
        return r;
    endfunction : mecc_view

endpackage : mecc_pkg

// File: design/mecc_top.sv
// SECDED-protected 512 x 72 memory with AHB-Lite control registers.
// Assumes write and read ports driven by logic on hclk; no synchronisers.
`timescale 1ns/1ps
module mecc_top (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output      logic                          hreadyout,
    output      logic                          hresp,
    output      logic [31:0]                   hrdata,
    input  wire logic                          write_enable,
    input  wire logic [mecc_pkg::ADDR_W-1:0]   write_address,
    input  wire logic [mecc_pkg::DATA_W-1:0]   write_word_in,
    input  wire logic [mecc_pkg::CHK_W-1:0]    check_bits_in,
    output      logic [mecc_pkg::CHK_W-1:0]    encoder_check_out,
    input  wire logic                          read_enable,
    input  wire logic [mecc_pkg::ADDR_W-1:0]   read_address,
    output      logic [mecc_pkg::DATA_W-1:0]   read_word_out,
    output      logic [mecc_pkg::CHK_W-1:0]    check_bits_out,
    output      logic                          single_error_flag,
    output      logic                          double_error_flag,
    output      logic                          read_valid
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mecc_pkg::mecc_cfg_t             cfg_q;
    logic [1:0]                      stat_q;
    logic [1:0]                      stat_set;
    logic [1:0]                      stat_clr;
    logic                            acc;
    logic                            ap_wr_q;
    logic [7:0]                      ap_addr_q;
    logic [31:0]                     hrdata_q;
    logic [31:0]                     rd_val;
    logic [mecc_pkg::ADDR_W-1:0]     wr_cnt_q;
    logic [mecc_pkg::ADDR_W-1:0]     rd_cnt_q;
    logic [mecc_pkg::ADDR_W-1:0]     wr_addr;
    logic [mecc_pkg::ADDR_W-1:0]     rd_addr;
    logic [mecc_pkg::CHK_W-1:0]      gen_chk;
    logic [mecc_pkg::WORD_W-1:0]     wr_word;
    logic [mecc_pkg::WORD_W-1:0]     rd_word;
    logic [mecc_pkg::WORD_W-1:0]     mem [mecc_pkg::DEPTH];
    logic [mecc_pkg::WORD_W-1:0]     raw_q;
    logic                            rd_vld_q;
    logic                            reg_vld_q;
    mecc_pkg::mecc_rd_t              lat;
    mecc_pkg::mecc_rd_t              reg_q;
    mecc_pkg::mecc_rd_t              out_s;
    logic [mecc_pkg::CHK_W-1:0]      enc_q;

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    assign acc       = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q   <= 1'b0;
            ap_addr_q <= 8'h00;
        end else begin
            ap_wr_q   <= acc && hwrite && (hsize == mecc_pkg::HSIZE_WORD);
            if (acc) ap_addr_q <= haddr[7:0];
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr[7:0] == mecc_pkg::OFS_CTRL) rd_val[3:0] = cfg_q;
        else if (haddr[7:0] == mecc_pkg::OFS_STAT) rd_val[1:0] = stat_q;
        else if (haddr[7:0] == mecc_pkg::OFS_PTR) rd_val = {7'h00, rd_cnt_q, 7'h00, wr_cnt_q};
    end

    // Read data prepared at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata_q <= rd_val;
        end
    end

    // Mode settings
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= mecc_pkg::CTRL_RST;
        end else if (ap_wr_q && ap_addr_q == mecc_pkg::OFS_CTRL) begin
            cfg_q <= mecc_pkg::mecc_cfg_t'(hwdata[3:0]);
        end
    end

    // Sticky error status, write one to clear, set wins
    assign stat_clr = (ap_wr_q && ap_addr_q == mecc_pkg::OFS_STAT) ? hwdata[1:0] : 2'h0;
    assign stat_set = read_valid ? {double_error_flag, single_error_flag} : 2'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= mecc_pkg::STAT_RST;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    // ------------------------------------------------------------
    // Address sources
    // ------------------------------------------------------------
    assign wr_addr = cfg_q.fifo ? wr_cnt_q : write_address;
    assign rd_addr = cfg_q.fifo ? rd_cnt_q : read_address;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_cnt_q <= 9'h000;
        end else if (cfg_q.fifo && write_enable) begin
            wr_cnt_q <= wr_cnt_q + 9'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_cnt_q <= 9'h000;
        end else if (cfg_q.fifo && read_enable) begin
            rd_cnt_q <= rd_cnt_q + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // Write port
    // ------------------------------------------------------------
    assign gen_chk = mecc_pkg::mecc_gen(write_word_in);
    assign wr_word = {cfg_q.enc ? gen_chk : check_bits_in, write_word_in};

    always_ff @(posedge hclk) begin
        if (write_enable) mem[wr_addr] <= wr_word;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enc_q <= 8'h00;
        end else if (write_enable && cfg_q.enc) begin
            enc_q <= gen_chk;
        end
    end

    assign encoder_check_out = enc_q;

    // ------------------------------------------------------------
    // Read port: capture, decode, optional output register
    // ------------------------------------------------------------
    assign rd_word = mem[rd_addr];

    // Stored word is only read, never written back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_q    <= '0;
            rd_vld_q <= 1'b0;
        end else begin
            rd_vld_q <= read_enable;
            if (read_enable) raw_q <= rd_word;
        end
    end

    assign lat = mecc_pkg::mecc_view(raw_q, cfg_q.dec);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_q     <= '0;
            reg_vld_q <= 1'b0;
        end else begin
            reg_vld_q <= rd_vld_q;
            if (rd_vld_q) reg_q <= lat;
        end
    end

    // Flags travel in the same carrier as the data
    assign out_s             = cfg_q.oreg ? reg_q : lat;
    assign read_valid        = cfg_q.oreg ? reg_vld_q : rd_vld_q;
    assign read_word_out     = out_s.data;
    assign check_bits_out    = out_s.check;
    assign single_error_flag = out_s.sbe;
    assign double_error_flag = out_s.dbe;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_enc_out;
        write_enable && cfg_q.enc |=>
            encoder_check_out == mecc_pkg::mecc_gen($past(write_word_in));
    endproperty
    a_enc_out: assert property (p_enc_out) else $error("encoder check output wrong");

    property p_store;
        write_enable && cfg_q.enc |=>
            mem[$past(wr_addr)] == {mecc_pkg::mecc_gen($past(write_word_in)), $past(write_word_in)};
    endproperty
    a_store: assert property (p_store) else $error("encoded word not stored");

    property p_ign;
        write_enable && cfg_q.enc && check_bits_in != gen_chk |=>
            mem[$past(wr_addr)][71:64] != $past(check_bits_in);
    endproperty
    a_ign: assert property (p_ign) else $error("external check bits stored");

    property p_plain_wr;
        write_enable && !cfg_q.enc |=>
            mem[$past(wr_addr)] == {$past(check_bits_in), $past(write_word_in)};
    endproperty
    a_plain_wr: assert property (p_plain_wr) else $error("plain write wrong");

    property p_latch;
        read_enable && !cfg_q.oreg ##1 $stable(cfg_q) |->
            out_s == mecc_pkg::mecc_view($past(rd_word), cfg_q.dec) && read_valid;
    endproperty
    a_latch: assert property (p_latch) else $error("latch mode read wrong");

    property p_regm;
        read_enable && cfg_q.oreg ##1 $stable(cfg_q) [*2] |->
            out_s == mecc_pkg::mecc_view($past(rd_word, 2), cfg_q.dec) && read_valid;
    endproperty
    a_regm: assert property (p_regm) else $error("register mode read wrong");

    property p_enc_only;
        !cfg_q.dec && !cfg_q.oreg |-> !single_error_flag && !double_error_flag;
    endproperty
    a_enc_only: assert property (p_enc_only) else $error("flag in encode-only");

    property p_keep;
        read_enable && !write_enable |=> mem[$past(rd_addr)] == $past(rd_word);
    endproperty
    a_keep: assert property (p_keep) else $error("stored word changed by read");

    property p_fix;
        single_error_flag |-> mecc_pkg::mecc_gen(read_word_out) == check_bits_out
            && !double_error_flag;
    endproperty
    a_fix: assert property (p_fix) else $error("single error not corrected");

    property p_dbl;
        double_error_flag && !cfg_q.oreg |-> {check_bits_out, read_word_out} == raw_q;
    endproperty
    a_dbl: assert property (p_dbl) else $error("double error word altered");

    property p_clean;
        !cfg_q.oreg && mecc_pkg::mecc_gen(raw_q[63:0]) == raw_q[71:64] |->
            !single_error_flag && !double_error_flag;
    endproperty
    a_clean: assert property (p_clean) else $error("flag on clean word");

    property p_fifo;
        cfg_q.fifo && read_enable |=> rd_cnt_q == $past(rd_cnt_q) + 9'h001;
    endproperty
    a_fifo: assert property (p_fifo) else $error("read counter not advanced");

    property p_indep;
        write_enable && !read_enable |=> $stable(raw_q);
    endproperty
    a_indep: assert property (p_indep) else $error("write disturbed read port");

    c_sbe:  cover property (read_valid && single_error_flag);
    c_dbe:  cover property (read_valid && double_error_flag);
    c_regm: cover property (cfg_q.oreg && cfg_q.dec && read_valid);
    c_fifo: cover property (cfg_q.fifo && write_enable ##[1:4] read_enable);

endmodule : mecc_top

// File: testbench/mecc_fabric.sv
// Behavioural user fabric that drives the memory write and read ports.
// Assumes the memory samples its ports on rising hclk edges.
`timescale 1ns/1ps
module mecc_fabric (
    input  wire logic                        hclk,
    output      logic                        write_enable,
    output      logic [mecc_pkg::ADDR_W-1:0] write_address,
    output      logic [mecc_pkg::DATA_W-1:0] write_word_in,
    output      logic [mecc_pkg::CHK_W-1:0]  check_bits_in,
    output      logic                        read_enable,
    output      logic [mecc_pkg::ADDR_W-1:0] read_address
);
    initial begin
        write_enable  = 1'h0;
        write_address = 9'h000;
        write_word_in = 64'h0000_0000_0000_0000;
        check_bits_in = 8'h00;
        read_enable   = 1'h0;
        read_address  = 9'h000;
    end

    // ------------------------------------------------------------
    // Port transfers; released lines show inverted values
    // ------------------------------------------------------------
    task automatic wr(input logic [8:0] a, input logic [63:0] d, input logic [7:0] c);
        @(posedge hclk);
        write_enable  <= 1'h1;
        write_address <= a;
        write_word_in <= d;
        check_bits_in <= c;
        @(posedge hclk);
        write_enable  <= 1'h0;
        write_address <= ~a;
        write_word_in <= ~d;
        check_bits_in <= ~c;
    endtask : wr

    task automatic rd(input logic [8:0] a);
        @(posedge hclk);
        read_enable  <= 1'h1;
        read_address <= a;
        @(posedge hclk);
        read_enable  <= 1'h0;
        read_address <= ~a;
    endtask : rd
endmodule : mecc_fabric

// File: testbench/mecc_top_tb.sv
// Self-checking bench for the SECDED memory: AHB-Lite master plus fabric model.
// Assumes mecc_top, mecc_fabric and mecc_pkg are compiled before it.
`timescale 1ns/1ps
module mecc_top_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        write_enable, read_enable, single_error_flag, double_error_flag, read_valid;
    logic [8:0]  write_address, read_address;
    logic [63:0] write_word_in, read_word_out;
    logic [7:0]  check_bits_in, encoder_check_out, check_bits_out;
    int          errors, checks_done, seed;
    int          cycles = 0;

    initial begin
        hclk = 1'h0;
        forever #12.5 hclk = ~hclk;
    end
    assign hready = hreadyout;

    mecc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .write_enable(write_enable),
        .write_address(write_address), .write_word_in(write_word_in),
        .check_bits_in(check_bits_in), .encoder_check_out(encoder_check_out),
        .read_enable(read_enable), .read_address(read_address),
        .read_word_out(read_word_out), .check_bits_out(check_bits_out),
        .single_error_flag(single_error_flag), .double_error_flag(double_error_flag),
        .read_valid(read_valid));

    mecc_fabric i_fab (.hclk(hclk), .write_enable(write_enable),
        .write_address(write_address), .write_word_in(write_word_in),
        .check_bits_in(check_bits_in), .read_enable(read_enable),
        .read_address(read_address));

    // ------------------------------------------------------------
    // Expected check bits and comparison helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] ecc(input logic [63:0] d);
        logic [7:0] c;
        int         j;
        c = 8'h00;
        j = 0;
        for (int p = 1; p < 72; p++) begin
            if ((p & (p - 1)) != 0) begin
                for (int b = 0; b < 7; b++) begin
                    if (p[b]) c[b] = c[b] ^ d[j];
                end
                j++;
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction : ecc

    task automatic chk(input logic [73:0] got, input logic [73:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        hsize  <= mecc_pkg::HSIZE_WORD;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hsel   <= 1'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        rd = hrdata;
        chk(74'(hresp), 74'h0, "response");
    endtask : ahb

    task automatic rd_check(input logic [8:0] a, input mecc_pkg::mecc_rd_t exp, input logic oreg);
        int n;
        i_fab.rd(a);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (read_valid !== 1'h1 && n < 4);
        chk(74'(n), 74'(oreg) + 74'h1, "read latency");
        chk({read_word_out, check_bits_out, single_error_flag, double_error_flag}, exp,
            "read result");
    endtask : rd_check

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0]        r;
        logic [63:0]        d, dd, d0;
        logic [7:0]         cc, pe;
        logic [71:0]        st;
        int                 i, i2, b, err;
        mecc_pkg::mecc_rd_t e;
        seed = 81;
        errors = 0;
        checks_done = 0;
        pe = 8'h00;
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        ahb(1'h0, mecc_pkg::OFS_CTRL, 32'h0000_0000, r);
        chk(74'(r), 74'(mecc_pkg::CTRL_RST), "ctrl reset");
        ahb(1'h0, mecc_pkg::OFS_STAT, 32'h0000_0000, r);
        chk(74'(r), 74'(mecc_pkg::STAT_RST), "stat reset");
        ahb(1'h0, 8'h0C, 32'h0000_0000, r);
        chk(74'(r), 74'h0, "unmapped read");
        $display("test registers done");
        for (int m = 0; m < 8; m++) begin
            ahb(1'h1, mecc_pkg::OFS_CTRL, 32'(m), r);
            for (int k = 0; k < 6; k++) begin
                d  = {$random(seed), $random(seed)};
                i  = $random(seed) & 63;
                i2 = (i + 1 + ($random(seed) & 31)) % 64;
                b  = $random(seed) & 7;
                dd = d ^ (64'(k == 1 || k == 3 || k == 4) << i) ^ (64'(k == 3) << i2);
                cc = ecc(d) ^ (8'(k == 2 || k >= 4) << b) ^ (8'(k == 5) << ((b + 1) % 8));
                i_fab.wr(9'(k), dd, m[0] ? ~cc : cc);
                @(negedge hclk);
                if (m[0]) pe = ecc(dd);
                chk(74'(encoder_check_out), 74'(pe), "encoder check");
                err = m[0] ? 0 : k;
                st  = m[0] ? {ecc(dd), dd} : {cc, dd};
                e   = {st[63:0], st[71:64], 2'h0};
                if (m[1] && (err == 1 || err == 2)) e = {d, ecc(d), 2'h2};
                else if (m[1] && err > 2) e.dbe = 1'h1;
                rd_check(9'(k), e, m[2]);
                rd_check(9'(k), e, m[2]);
            end
            $display("test mode %0d done", m);
        end
        ahb(1'h0, mecc_pkg::OFS_STAT, 32'h0000_0000, r);
        chk(74'(r[1:0]), 74'h3, "sticky status");
        ahb(1'h1, mecc_pkg::OFS_STAT, 32'h0000_0003, r);
        ahb(1'h0, mecc_pkg::OFS_STAT, 32'h0000_0000, r);
        chk(74'(r[1:0]), 74'h0, "status cleared");
        ahb(1'h1, mecc_pkg::OFS_CTRL, 32'h0000_000B, r);
        for (int k = 0; k < 3; k++) begin
            d = {$random(seed), $random(seed)};
            if (k == 0) d0 = d;
            i_fab.wr(9'h1FF, d, 8'h00);
        end
        rd_check(9'h155, {d0, ecc(d0), 2'h0}, 1'h0);
        ahb(1'h0, mecc_pkg::OFS_PTR, 32'h0000_0000, r);
        chk(74'(r), 74'h1_0003, "fifo counters");
        $display("test fifo done");
        stop_test();
    end
endmodule : mecc_top_tb
